/* File: hw/pcc_consts.vh */
// Operation
// (R01) Power field 01b holds loop powered down
// (R02) Power field 00b runs loop normally
// (R03) Source bit0 set bypasses VCO divider
// (R04) Source bit1 clear selects external clock input
// (R05) Polarity bit: 0 positive, 1 negative
// (R06) Polarity matters only with external VCO
// (R07) Values apply only after update write 0x01
// (R08) Detector compares reference and feedback dividers
// (R09) Two-bit field selects antibacklash width
// (R10) Pump mode: tristate, normal, up, down
// (R11) Pump current selectable in eight steps
// (R12) Software calibrates at setup and retune
// (R13) Reference present, divider not static, during calibration
// (R14) Bit0 clear uses divider; bit1 set VCO
// (R15) VCO divider field selects 2 to 6
// (R16) Calibration starts on bit set plus update
// (R17) Update transfers all pending values together
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH
// Register indices, byte address is four times these
`define PCC_IDX_LOOP 12'h010
`define PCC_IDX_CP_CURRENT 12'h011
`define PCC_IDX_ABL 12'h017
`define PCC_IDX_CAL 12'h018
`define PCC_IDX_VCODIV 12'h1E0
`define PCC_IDX_SRC 12'h1E1
`define PCC_IDX_UPDATE 12'h232
`define PCC_IDX_STATUS 12'h233
// Update trigger value
`define PCC_UPDATE_CODE 8'h01
// Reset values
`define PCC_RST_LOOP 8'h01
`define PCC_RST_CP_CURRENT 8'h07
`define PCC_RST_ABL 8'h00
`define PCC_RST_CAL 8'h00
`define PCC_RST_VCODIV 8'h02
`define PCC_RST_SRC 8'h00
// Loop power codes
`define PCC_PWR_NORMAL 2'h0
`define PCC_PWR_DOWN 2'h1
// Pump modes
`define PCC_CP_TRISTATE 3'h0
`define PCC_CP_UP 3'h1
`define PCC_CP_DOWN 3'h2
`define PCC_CP_NORMAL 3'h3
// Calibration length in cycles
`define PCC_CAL_CYCLES 16'h0400
`endif

/* File: hw/pcc_pfd.v */
`include "pcc_consts.vh"
// Phase frequency detector with antibacklash stretch
module pcc_pfd (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Divider edges, same domain
	input wire ref_edge,
	input wire fb_edge,
	input wire [1:0] abl_sel,
	// Detector outputs
	output reg det_up,
	output reg det_down
);
	reg up_lat; // Reference arrived first
	reg dn_lat; // Feedback arrived first
	reg [2:0] abl_cnt; // Overlap stretch counter
	// Three-state detector; both latched clears after the delay
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_lat <= 1'b0;
			dn_lat <= 1'b0;
			abl_cnt <= 3'h0;
			det_up <= 1'b0;
			det_down <= 1'b0;
		end else begin
			if (up_lat && dn_lat) begin
				// Short overlap avoids a dead zone
				if (abl_cnt == {1'b0, abl_sel}) begin // R09
					up_lat <= 1'b0;
					dn_lat <= 1'b0;
					abl_cnt <= 3'h0;
				end else begin
					abl_cnt <= abl_cnt + 3'h1;
				end
			end else begin
				if (ref_edge)
					up_lat <= 1'b1; // R08
				if (fb_edge)
					dn_lat <= 1'b1; // R08
			end
			det_up <= up_lat;
			det_down <= dn_lat;
		end
	end
endmodule

/* File: hw/pcc_shadow.v */
`include "pcc_consts.vh"
// Pending and active copy of one configuration byte
module pcc_shadow #(
	parameter [7:0] RESET_VALUE = 8'h00
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Software side
	input wire wr_en,
	input wire [7:0] wr_data,
	input wire apply,
	// Values
	output reg [7:0] pending,
	output reg [7:0] active
);
	// Pending takes writes, active copies only on update
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= RESET_VALUE;
			active <= RESET_VALUE;
		end else begin
			if (wr_en)
				pending <= wr_data;
			if (apply)
				active <= pending; // R07 R17
		end
	end
endmodule

/* File: hw/pcc_top.v */
`include "pcc_consts.vh"
// Clock path configuration with APB register access
module pcc_top #(
	parameter CAL_CYCLES = `PCC_CAL_CYCLES
) (
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Divider edges from the loop, asynchronous
	input wire ref_div_in,
	input wire fb_div_in,
	// Loop controls
	output reg loop_off,
	output reg dist_use_vco,
	output reg dist_bypass_div,
	output reg [2:0] vco_div_ratio,
	output reg pump_up,
	output reg pump_down,
	output reg pump_tristate,
	output reg [2:0] pump_current,
	output reg [1:0] abl_width,
	output reg cal_busy
);
	////////////////////////////////////////////////////////////////
	// Bus decode
	wire [9:0] idx = paddr[11:2]; // Word index
	wire acc = psel && penable; // Access phase
	wire wr = acc && pwrite;
	// Index match for an address
	function hit;
		input [9:0] a;
		input [11:0] r;
		begin
			hit = (a == r[9:0]);
		end
	endfunction
	wire known = hit(idx, `PCC_IDX_LOOP) || hit(idx, `PCC_IDX_CP_CURRENT) ||
		hit(idx, `PCC_IDX_ABL) || hit(idx, `PCC_IDX_CAL) || hit(idx, `PCC_IDX_VCODIV) ||
		hit(idx, `PCC_IDX_SRC) || hit(idx, `PCC_IDX_UPDATE) || hit(idx, `PCC_IDX_STATUS);
	// Address width limits the map; index 0x233 needs ten bits
	wire apply = wr && hit(idx, `PCC_IDX_UPDATE) && (pwdata[7:0] == `PCC_UPDATE_CODE); // R07
	////////////////////////////////////////////////////////////////
	// Shadowed configuration
	wire [7:0] p_loop, a_loop, p_cur, a_cur, p_abl, a_abl, p_cal, a_cal;
	wire [7:0] p_div, a_div, p_src, a_src;
	pcc_shadow #(.RESET_VALUE(`PCC_RST_LOOP)) u_loop (.pclk(pclk), .presetn(presetn),
		.wr_en(wr && hit(idx, `PCC_IDX_LOOP)), .wr_data(pwdata[7:0]), .apply(apply),
		.pending(p_loop), .active(a_loop));
	pcc_shadow #(.RESET_VALUE(`PCC_RST_CP_CURRENT)) u_cur (.pclk(pclk), .presetn(presetn),
		.wr_en(wr && hit(idx, `PCC_IDX_CP_CURRENT)), .wr_data(pwdata[7:0]), .apply(apply),
		.pending(p_cur), .active(a_cur));
	pcc_shadow #(.RESET_VALUE(`PCC_RST_ABL)) u_abl (.pclk(pclk), .presetn(presetn),
		.wr_en(wr && hit(idx, `PCC_IDX_ABL)), .wr_data(pwdata[7:0]), .apply(apply),
		.pending(p_abl), .active(a_abl));
	pcc_shadow #(.RESET_VALUE(`PCC_RST_CAL)) u_cal (.pclk(pclk), .presetn(presetn),
		.wr_en(wr && hit(idx, `PCC_IDX_CAL)), .wr_data(pwdata[7:0]), .apply(apply),
		.pending(p_cal), .active(a_cal));
	pcc_shadow #(.RESET_VALUE(`PCC_RST_VCODIV)) u_div (.pclk(pclk), .presetn(presetn),
		.wr_en(wr && hit(idx, `PCC_IDX_VCODIV)), .wr_data(pwdata[7:0]), .apply(apply),
		.pending(p_div), .active(a_div));
	pcc_shadow #(.RESET_VALUE(`PCC_RST_SRC)) u_src (.pclk(pclk), .presetn(presetn),
		.wr_en(wr && hit(idx, `PCC_IDX_SRC)), .wr_data(pwdata[7:0]), .apply(apply),
		.pending(p_src), .active(a_src));
	////////////////////////////////////////////////////////////////
	// Divider edge synchronisers and edge detect
	reg [2:0] ref_sync; // Bit0 first stage, read only by bit1
	reg [2:0] fb_sync;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_sync <= 3'h0;
			fb_sync <= 3'h0;
		end else begin
			ref_sync <= {ref_sync[1:0], ref_div_in};
			fb_sync <= {fb_sync[1:0], fb_div_in};
		end
	end
	wire ref_edge = ref_sync[1] && !ref_sync[2];
	wire fb_edge = fb_sync[1] && !fb_sync[2];
	wire det_up, det_down;
	pcc_pfd u_pfd (.pclk(pclk), .presetn(presetn), .ref_edge(ref_edge), .fb_edge(fb_edge),
		.abl_sel(a_abl[1:0]), .det_up(det_up), .det_down(det_down));
	////////////////////////////////////////////////////////////////
	// Calibration sequencer
	localparam CAL_IDLE = 3'b001;
	localparam CAL_RUN = 3'b010;
	localparam CAL_DONE = 3'b100;
	reg [2:0] cal_state;
	reg [15:0] cal_cnt; // Remaining cycles
	reg cal_done_flag; // Completed since last arm
	// Run once per rising edge of the active bit; re-arm needs a clear first
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_state <= CAL_IDLE;
			cal_cnt <= 16'h0000;
			cal_done_flag <= 1'b0;
		end else begin
			case (cal_state)
				CAL_IDLE: begin
					if (a_cal[0] && a_loop[1:0] == `PCC_PWR_NORMAL) begin // R16
						cal_state <= CAL_RUN;
						cal_cnt <= CAL_CYCLES[15:0];
						cal_done_flag <= 1'b0;
					end
				end
				CAL_RUN: begin
					if (cal_cnt <= 16'h0001) begin
						cal_state <= CAL_DONE;
						cal_done_flag <= 1'b1;
					end else begin
						cal_cnt <= cal_cnt - 16'h0001;
					end
				end
				CAL_DONE: begin
					// Wait for software to clear the bit and update
					if (!a_cal[0])
						cal_state <= CAL_IDLE; // R16
				end
				default: begin
					cal_state <= CAL_IDLE;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// Loop outputs from active settings only
	reg next_up, next_down;
	// Pump mode and polarity decode
	always @* begin
		next_up = 1'b0;
		next_down = 1'b0;
		case (a_loop[6:4]) // R10
			`PCC_CP_UP: next_up = 1'b1;
			`PCC_CP_DOWN: next_down = 1'b1;
			`PCC_CP_NORMAL: begin
				// Polarity swaps pump sense for external VCO only
				if (a_loop[7] && !a_src[1]) begin // R05 R06
					next_up = det_down;
					next_down = det_up;
				end else begin
					next_up = det_up; // R08
					next_down = det_down;
				end
			end
			default: begin
				next_up = 1'b0;
				next_down = 1'b0;
			end
		endcase
		// Powered-down loop never pumps
		if (a_loop[1:0] != `PCC_PWR_NORMAL) begin // R01
			next_up = 1'b0;
			next_down = 1'b0;
		end
	end
	// Registered outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_off <= 1'b1;
			dist_use_vco <= 1'b0;
			dist_bypass_div <= 1'b0;
			vco_div_ratio <= 3'h2;
			pump_up <= 1'b0;
			pump_down <= 1'b0;
			pump_tristate <= 1'b1;
			pump_current <= 3'h7;
			abl_width <= 2'h0;
			cal_busy <= 1'b0;
		end else begin
			loop_off <= (a_loop[1:0] != `PCC_PWR_NORMAL); // R01 R02
			dist_use_vco <= a_src[1]; // R04 R14
			dist_bypass_div <= a_src[0]; // R03 R14
			// Ratio field holds 2 to 6; codes above 4 clamp to code 4
			vco_div_ratio <= (a_div[2:0] > 3'h4) ? 3'h4 : a_div[2:0]; // R15
			pump_up <= next_up;
			pump_down <= next_down;
			pump_tristate <= !(next_up || next_down);
			pump_current <= a_cur[2:0]; // R11
			abl_width <= a_abl[1:0]; // R09
			cal_busy <= (cal_state == CAL_RUN);
		end
	end
	////////////////////////////////////////////////////////////////
	// APB read and response, zero wait states
	reg [7:0] rd_byte;
	always @* begin
		rd_byte = 8'h00;
		if (hit(idx, `PCC_IDX_LOOP)) rd_byte = p_loop;
		else if (hit(idx, `PCC_IDX_CP_CURRENT)) rd_byte = p_cur;
		else if (hit(idx, `PCC_IDX_ABL)) rd_byte = p_abl;
		else if (hit(idx, `PCC_IDX_CAL)) rd_byte = p_cal;
		else if (hit(idx, `PCC_IDX_VCODIV)) rd_byte = p_div;
		else if (hit(idx, `PCC_IDX_SRC)) rd_byte = p_src;
		else if (hit(idx, `PCC_IDX_STATUS))
			rd_byte = {5'h00, cal_done_flag, cal_state == CAL_RUN, a_loop[1:0] == `PCC_PWR_NORMAL};
	end
	// Response registers; update register reads as zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !known;
			prdata <= {24'h000000, rd_byte};
		end
	end
endmodule

/* File: verification/pcc_checker.sv */
////////////////////////////////////////////////////////////
// Port-level checks of the clock path configuration block
module pcc_checker #(
	parameter CAL_CYCLES = 1024
) (
	// Register bus
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Loop controls
	input wire loop_off,
	input wire dist_use_vco,
	input wire dist_bypass_div,
	input wire [2:0] vco_div_ratio,
	input wire pump_up,
	input wire pump_down,
	input wire pump_tristate,
	input wire [2:0] pump_current,
	input wire [1:0] abl_width,
	input wire cal_busy
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Settings that may only move after an apply write
	wire [10:0] cfg = {loop_off, dist_use_vco, dist_bypass_div, vco_div_ratio, pump_current, abl_width};
	// Apply write accepted at this edge
	wire upd_w = psel && penable && pwrite && paddr == 12'h8C8 && pwdata[7:0] == 8'h01;
	// Length of the current calibration run
	int unsigned busy_len;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_len <= 0;
		else
			busy_len <= cal_busy ? busy_len + 1 : 0;
	end
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence pump_off_s;
		loop_off [*3];
	endsequence
	chk_ready_after_setup: assert property (setup_s |=> pready) else $error("no ready after setup");
	chk_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
	chk_cfg_update: assert property (!$stable(cfg) |-> $past(upd_w) || $past(upd_w, 2) || $past(upd_w, 3))
		else $error("settings moved without apply");
	chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	chk_off_no_pump: assert property (pump_off_s |-> !pump_up && !pump_down)
		else $error("pump active while loop off");
	chk_tristate_idle: assert property (pump_tristate [*2] |-> !pump_up && !pump_down)
		else $error("pump active in tristate");
	chk_cal_bounded: assert property (busy_len <= CAL_CYCLES + 2)
		else $error("calibration too long");
	chk_read_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
	chk_ratio_clamp: assert property (vco_div_ratio <= 3'h4)
		else $error("divider code out of range");
endmodule
bind pcc_top pcc_checker #(.CAL_CYCLES(CAL_CYCLES)) i_pcc_checker (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .loop_off(loop_off), .dist_use_vco(dist_use_vco),
	.dist_bypass_div(dist_bypass_div), .vco_div_ratio(vco_div_ratio), .pump_up(pump_up),
	.pump_down(pump_down), .pump_tristate(pump_tristate), .pump_current(pump_current),
	.abl_width(abl_width), .cal_busy(cal_busy));

/* File: verification/pcc_top_tb_top.sv */
`include "pcc_consts.vh"
////////////////////////////////////////////////////////////
// Register-level test of the clock path configuration block
module pcc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ref_div_in = 0, fb_div_in = 0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	wire [31:0] prdata;
	wire pready, pslverr, loop_off, dist_use_vco, dist_bypass_div, pump_up, pump_down, pump_tristate, cal_busy;
	wire [2:0] vco_div_ratio, pump_current;
	wire [1:0] abl_width;
	wire [14:0] outs = {loop_off, dist_use_vco, dist_bypass_div, vco_div_ratio, pump_up, pump_down,
		pump_tristate, pump_current, abl_width, cal_busy};
	int bad_count = 0, cmp_count = 0, cyc = 0, n;
	always #2 pclk = ~pclk;
	// Short calibration keeps the run brief
	pcc_top #(.CAL_CYCLES(8)) i_pcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ref_div_in(ref_div_in), .fb_div_in(fb_div_in), .loop_off(loop_off), .dist_use_vco(dist_use_vco),
		.dist_bypass_div(dist_bypass_div), .vco_div_ratio(vco_div_ratio), .pump_up(pump_up),
		.pump_down(pump_down), .pump_tristate(pump_tristate), .pump_current(pump_current),
		.abl_width(abl_width), .cal_busy(cal_busy));
	task end_sim;
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	// One bus transfer, held until ready is sampled
	task acc(input logic w, input logic [11:0] i, input logic [7:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {i[9:0], 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		// Wait as long as the slave needs; the hang guard ends a stuck run
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task upd;
		acc(1, `PCC_IDX_UPDATE, `PCC_UPDATE_CODE);
		repeat (2) @(posedge pclk);
	endtask
	task wr_upd(input logic [11:0] i, input logic [7:0] d);
		acc(1, i, d);
		upd;
	endtask
	// Reference edge alone, then feedback edge to settle
	task edge_test(input logic [7:0] lp, input logic [1:0] e);
		wr_upd(`PCC_IDX_LOOP, lp);
		ref_div_in <= 1;
		n = 0;
		while (!(pump_up | pump_down) && n < 16) begin
			@(posedge pclk);
			n++;
		end
		chk({pump_up, pump_down}, e);
		fb_div_in <= 1;
		repeat (8) @(posedge pclk);
		ref_div_in <= 0;
		fb_div_in <= 0;
		repeat (4) @(posedge pclk);
	endtask
	task wait_busy(input logic v);
		n = 0;
		while (cal_busy !== v && n < 40) begin
			// Reference keeps running while calibration may be in progress
			ref_div_in <= ~ref_div_in;
			@(posedge pclk);
			n++;
		end
		chk(cal_busy, v);
	endtask
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			end_sim;
		end
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk(outs, 15'h4478);
		acc(1, `PCC_IDX_LOOP, 8'h10);
		acc(0, `PCC_IDX_LOOP, 8'h00);
		chk(rd, 32'h10);
		chk(loop_off, 1'b1);
		upd;
		chk(loop_off, 1'b0);
		for (int m = 0; m < 4; m++) begin
			wr_upd(`PCC_IDX_LOOP, {1'b0, m[2:0], 4'h0});
			// Normal mode with no detector pulse leaves the pump idle
			chk({pump_up, pump_down, pump_tristate}, m == 1 ? 3'b100 : m == 2 ? 3'b010 : 3'b001);
		end
		edge_test(8'h30, 2'b10);
		edge_test(8'hB0, 2'b01);
		wr_upd(`PCC_IDX_SRC, 8'h02);
		chk({dist_use_vco, dist_bypass_div}, 2'b10);
		edge_test(8'hB0, 2'b10);
		acc(1, `PCC_IDX_SRC, 8'h01);
		acc(1, `PCC_IDX_ABL, 8'h03);
		acc(1, `PCC_IDX_CP_CURRENT, 8'h05);
		chk({dist_use_vco, dist_bypass_div, abl_width, pump_current}, 7'h47);
		upd;
		chk({dist_use_vco, dist_bypass_div, abl_width, pump_current}, 7'h3D);
		wr_upd(`PCC_IDX_SRC, 8'h00);
		chk({dist_use_vco, dist_bypass_div}, 2'b00);
		for (int c = 0; c < 8; c++) begin
			wr_upd(`PCC_IDX_VCODIV, c[7:0]);
			chk(vco_div_ratio, c > 4 ? 3'h4 : c[2:0]);
		end
		acc(0, 12'h001, 8'h00);
		// Unmapped word answers with an error and reads zero
		chk(err, 1'b1);
		chk(rd, 32'h0);
		wr_upd(`PCC_IDX_CAL, 8'h01);
		wait_busy(1);
		wait_busy(0);
		acc(0, `PCC_IDX_STATUS, 8'h00);
		chk(rd, 32'h5);
		upd;
		repeat (4) @(posedge pclk);
		chk(cal_busy, 1'b0);
		wr_upd(`PCC_IDX_CAL, 8'h00);
		wr_upd(`PCC_IDX_CAL, 8'h01);
		wait_busy(1);
		wr_upd(`PCC_IDX_LOOP, 8'h01);
		chk(loop_off, 1'b1);
		end_sim;
	end
endmodule
